/* include/jgh_pkg.sv */
// Shared constants and types for the jog and gain command handler
package jgh_pkg;
	localparam int AXES = 4;
	localparam int ADDR_W = 6;
	localparam int COEF_W = 22;
	localparam int FRAC_BITS = 8;
	// Register byte offsets
	localparam logic [5:0] A_CMD = 6'h00;
	localparam logic [5:0] A_ARG = 6'h04;
	localparam logic [5:0] A_CFG = 6'h08;
	localparam logic [5:0] A_STAT = 6'h0C;
	localparam logic [5:0] A_COST = 6'h10;
	localparam logic [5:0] A_IRQ = 6'h14;
	localparam logic [5:0] A_MASK = 6'h18;
	localparam logic [5:0] A_KA = 6'h1C;
	localparam logic [5:0] A_KB = 6'h20;
	localparam logic [5:0] A_VEL = 6'h24;
	// Command word: opcode in top nibble, axis mask in low nibble
	localparam int OP_LSB = 28;
	localparam logic [3:0] OP_SELECT = 4'h0;
	localparam logic [3:0] OP_MOVE = 4'h1;
	localparam logic [3:0] OP_TIMED = 4'h2;
	localparam logic [3:0] OP_LINKED = 4'h3;
	localparam logic [3:0] OP_NOTIFY = 4'h4;
	localparam logic [3:0] OP_JOG = 4'h5;
	localparam logic [3:0] OP_FJOG = 4'h6;
	localparam logic [3:0] OP_VEL = 4'h7;
	localparam logic [3:0] OP_SET_KA = 4'h8;
	localparam logic [3:0] OP_SET_KB = 4'h9;
	localparam logic [3:0] OP_RPT_KA = 4'hA;
	localparam logic [3:0] OP_RPT_KB = 4'hB;
	localparam logic [3:0] OP_STOP = 4'hC;
	localparam logic [3:0] OP_STOP_ALL = 4'hD;
	localparam logic [3:0] OP_KILL = 4'hE;
	localparam logic [3:0] OP_HOLD_OFF = 4'hF;
	// Configuration fields
	localparam int CFG_PA = 0;
	localparam int CFG_RAMP_LSB = 1;
	localparam int CFG_CLOSED_LSB = 4;
	localparam int CFG_LIMEN_LSB = 8;
	localparam int CFG_SEG_LSB = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [1:0] RAMP_LIN = 2'h0;
	localparam logic [1:0] RAMP_SHORT = 2'h1;
	localparam logic [1:0] RAMP_OTHER = 2'h2;
	localparam logic [1:0] RAMP_CUSTOM = 2'h3;
	// Queue cost figures
	localparam logic [7:0] COST_JOG_CMD = 8'h03;
	localparam logic [7:0] COST_ONE = 8'h01;
	localparam logic [7:0] COST_RESTORE_CMD = 8'h04;
	localparam logic [15:0] ARG_JG = 16'h0001;
	localparam logic [15:0] ARG_JF = 16'h0000;
	localparam logic [15:0] ARG_LIN = 16'h0004;
	localparam logic [15:0] ARG_SHORT = 16'h0006;
	localparam logic [15:0] ARG_OTHER = 16'h0016;
	localparam logic [15:0] ARG_CUSTOM_BASE = 16'h0002;
	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_RPT = 1;
	localparam int IRQ_VEL = 2;
	localparam int IRQ_REJ = 3;
	// Ranges and resets, coefficients in hundredths
	localparam logic [31:0] JOG_LIMIT = 32'h000F_EE20;
	localparam logic [21:0] KA_MAX = 22'h31FF9C;
	localparam logic [21:0] KB_MAX = 22'h0003E8;
	localparam logic [21:0] KA_RST = 22'h000000;
	localparam logic [21:0] KB_RST = 22'h000000;
	// Host characters
	localparam logic [7:0] DONE_CHAR_BASE = 8'h80;
	localparam logic [7:0] CH_K = 8'h6B;
	localparam logic [7:0] CH_A = 8'h61;
	localparam logic [7:0] CH_B = 8'h62;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [2:0] UNITS_POS = 3'h4;
	localparam logic [2:0] LAST_POS = 3'h6;
	localparam logic [21:0] POW10 [7] = '{22'h0F4240, 22'h0186A0, 22'h002710, 22'h0003E8,
		22'h000064, 22'h00000A, 22'h000001};
	typedef logic [COEF_W-1:0] jgh_coef_t;
	typedef logic signed [31:0] jgh_vel_t;
endpackage

/* src/jgh_fmt.sv */
// Host character sender for done bytes and coefficient reports
`timescale 1ns/10ps
module jgh_fmt (
	input wire logic i_clk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic [jgh_pkg::AXES-1:0] i_done_req, // Pending done bytes
	input wire logic i_rpt, // Report start pulse
	input wire logic i_rpt_kb, // Report upper bound, not feedforward
	input wire jgh_pkg::jgh_coef_t i_val, // Value in hundredths
	input wire logic i_tx_ready, // Link accepts byte
	output logic [jgh_pkg::AXES-1:0] o_done_ack, // Done byte sent pulse
	output logic o_busy, // Report in progress
	output logic o_rpt_done, // Report last byte pulse
	output logic [7:0] o_tx_data, // Byte to host
	output logic o_tx_valid // Byte valid
);
	import jgh_pkg::*;
	typedef enum logic [2:0] {F_IDLE, F_PFX, F_SUB, F_DOT, F_LF} jgh_fmt_e;
	jgh_fmt_e st_q;
	jgh_coef_t rem_q;
	logic [2:0] k_q;
	logic [3:0] dig_q;
	logic started_q, kb_q, pfx_q, free;
	logic [1:0] idx;
	assign free = !o_tx_valid;
	assign o_busy = st_q != F_IDLE;
	always_comb begin
		idx = 2'h0;
		for (int i = AXES - 1; i >= 0; i--) begin
			if (i_done_req[i]) begin
				idx = 2'(i);
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= F_IDLE;
			rem_q <= '0;
			k_q <= '0;
			dig_q <= '0;
			started_q <= 1'b0;
			kb_q <= 1'b0;
			pfx_q <= 1'b0;
			o_done_ack <= '0;
			o_rpt_done <= 1'b0;
			o_tx_data <= '0;
			o_tx_valid <= 1'b0;
		end else begin
			o_done_ack <= '0;
			o_rpt_done <= 1'b0;
			if (o_tx_valid && i_tx_ready) begin
				o_tx_valid <= 1'b0;
			end
			unique case (st_q)
				F_IDLE: if (i_rpt) begin
					rem_q <= i_val; // R12
					kb_q <= i_rpt_kb;
					k_q <= '0;
					dig_q <= '0;
					started_q <= 1'b0;
					pfx_q <= 1'b0;
					st_q <= F_PFX;
				end else if (free && |i_done_req) begin
					o_tx_data <= DONE_CHAR_BASE | {6'h00, idx}; // R2
					o_tx_valid <= 1'b1;
					o_done_ack[idx] <= 1'b1; // R1
				end
				F_PFX: if (free) begin
					o_tx_data <= !pfx_q ? CH_K : (kb_q ? CH_B : CH_A);
					o_tx_valid <= 1'b1;
					pfx_q <= 1'b1;
					if (pfx_q) begin
						st_q <= F_SUB;
					end
				end
				F_SUB: if (free) begin
					if (rem_q >= POW10[k_q]) begin
						rem_q <= rem_q - POW10[k_q];
						dig_q <= 4'(dig_q + 4'h1);
					end else begin
						if (dig_q != 0 || started_q || k_q == UNITS_POS) begin
							o_tx_data <= CH_0 | {4'h0, dig_q};
							o_tx_valid <= 1'b1;
							started_q <= 1'b1;
						end
						dig_q <= '0;
						k_q <= 3'(k_q + 3'h1);
						if (k_q == LAST_POS) begin
							st_q <= F_LF;
						end else if (k_q == UNITS_POS) begin
							st_q <= F_DOT;
						end
					end
				end
				F_DOT: if (free) begin
					o_tx_data <= CH_DOT;
					o_tx_valid <= 1'b1;
					st_q <= F_SUB;
				end
				F_LF: if (free) begin
					o_tx_data <= CH_LF; // R12
					o_tx_valid <= 1'b1;
					o_rpt_done <= 1'b1;
					st_q <= F_IDLE;
				end
			endcase
		end
	end
	done_char_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R2
		(|o_done_ack) |-> (o_tx_valid && o_tx_data == (DONE_CHAR_BASE | {6'h00, $past(idx)})))
		else $error("done byte does not name its axis");
	report_end_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R12
		o_rpt_done |-> (o_tx_valid && o_tx_data == CH_LF && !o_busy))
		else $error("report did not end with line feed");
endmodule // jgh_fmt

/* src/jgh_jog_axis.sv */
// Per-axis jog velocity sequencer
`timescale 1ns/10ps
module jgh_jog_axis (
	input wire logic i_clk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_jog, // Jog request pulse
	input wire jgh_pkg::jgh_vel_t i_vel, // Requested velocity
	input wire logic i_stop, // Stop request pulse
	input wire logic i_stopped, // Axis at standstill
	input wire logic i_at_vel, // Profile at target
	output jgh_pkg::jgh_vel_t o_target, // Target velocity
	output logic o_run, // Jog active
	output logic o_reversing, // Ramping down to reverse
	output logic o_at_vel_evt // Target reached pulse
);
	import jgh_pkg::*;
	typedef enum logic [1:0] {J_IDLE, J_RUN, J_DOWN} jgh_jog_e;
	jgh_jog_e st_q;
	jgh_vel_t pend_q;
	logic reached_q;
	logic flip;
	assign flip = (i_vel[31] != o_target[31]) && (i_vel != 0) && (o_target != 0);
	assign o_run = st_q != J_IDLE;
	assign o_reversing = st_q == J_DOWN;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= J_IDLE;
			o_target <= '0;
			pend_q <= '0;
			reached_q <= 1'b0;
			o_at_vel_evt <= 1'b0;
		end else begin
			o_at_vel_evt <= 1'b0;
			if (i_stop) begin
				st_q <= J_IDLE; // R6
				o_target <= '0;
			end else begin
				unique case (st_q)
					J_IDLE: if (i_jog) begin
						o_target <= i_vel; // R8
						reached_q <= 1'b0;
						st_q <= J_RUN;
					end
					J_RUN: if (i_jog && flip) begin
						pend_q <= i_vel; // R7
						o_target <= '0;
						st_q <= J_DOWN;
					end else if (i_jog) begin
						o_target <= i_vel; // R6
						reached_q <= 1'b0;
					end else if (i_at_vel && !reached_q) begin
						reached_q <= 1'b1; // R10
						o_at_vel_evt <= 1'b1;
					end
					J_DOWN: if (i_jog) begin
						pend_q <= i_vel;
					end else if (i_stopped) begin
						o_target <= pend_q; // R7
						reached_q <= 1'b0;
						st_q <= J_RUN;
					end
				endcase
			end
		end
	end
	reverse_wait_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
		(st_q == J_RUN && i_jog && flip && !i_stop) |=> (o_reversing && o_target == 0))
		else $error("reversal did not ramp down first");
	stop_ends_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R6
		i_stop |=> (!o_run && o_target == 0))
		else $error("stop did not end jog");
	at_vel_evt_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R10
		o_at_vel_evt |-> ($past(i_at_vel) && reached_q && o_run))
		else $error("release event without target reached");
endmodule // jgh_jog_axis

/* src/jgh_top.sv */
// Jog and gain command handler top level
// Overview of operation
// R1 - After notify command, each axis given a position reports done once.
// R2 - Done byte is 80 hex plus axis index, X 80 through T 83.
// R3 - Fractional jog takes fractional velocity, kept until replaced.
// R4 - Jog cost is three entries, plus power-auto and closed-loop extras.
// R5 - After timed or linked move, restore profile; extra cost by ramp.
// R6 - Jog ramps to velocity, runs until stop, kill, hold-off, jog, limit.
// R7 - Direction reversal ramps the axis to a stop before reversing.
// R8 - Jog overwrites move velocity and starts motion without go command.
// R9 - Host keeps jog velocities within plus or minus 1,044,000 counts/s.
// R10 - Events waiting on jog release when axis reaches its velocity.
// R11 - Feedforward defaults zero, accepts 0.00 to 32767.00, feeds PID.
// R12 - Feedforward report sends prefix, value and line feed immediately.
// R13 - Upper bound clamps servo output, default 0.00, range 0.0 to 10.0.
// R14 - Commands act in arrival order on the latest selected axes.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module jgh_top (
	input wire logic I_SYS_CLK, // 40 MHz clock
	input wire logic I_ARST_N, // Async reset, active low
	input wire logic [jgh_pkg::ADDR_W-1:0] I_ADDR, // Register byte address
	input wire logic [31:0] I_WDATA, // Write data
	input wire logic I_WR, // Write strobe
	input wire logic I_RD, // Read strobe
	output logic [31:0] O_RDATA, // Read data
	output logic O_IRQ, // Interrupt level
	input wire logic [jgh_pkg::AXES-1:0] I_AXIS_DONE, // Move complete pulse
	input wire logic [jgh_pkg::AXES-1:0] I_AT_VEL, // Profile at target
	input wire logic [jgh_pkg::AXES-1:0] I_STOPPED, // Axis standstill
	input wire logic [jgh_pkg::AXES-1:0] I_LIMIT, // Limit switch pins
	input wire logic [16*jgh_pkg::AXES-1:0] I_PID_OUT, // Signed PID outputs
	input wire logic I_TX_READY, // Link accepts byte
	output logic [7:0] O_TX_DATA, // Byte to host
	output logic O_TX_VALID, // Byte valid
	output logic [32*jgh_pkg::AXES-1:0] O_JOG_VEL, // Jog targets, signed 24.8
	output logic [jgh_pkg::AXES-1:0] O_JOG_RUN, // Jog active
	output logic [jgh_pkg::AXES-1:0] O_REVERSING, // Ramping down to reverse
	output logic [32*jgh_pkg::AXES-1:0] O_MOVE_VEL, // Move velocities, 24.8
	output logic [jgh_pkg::AXES-1:0] O_RESTORE, // Restore profile pulse
	output logic O_KILL, // Kill pulse
	output logic [jgh_pkg::COEF_W*jgh_pkg::AXES-1:0] O_ACCEL_FF, // Feedforward
	output logic [16*jgh_pkg::AXES-1:0] O_DAC_OUT // Clamped servo outputs
);
	import jgh_pkg::*;
	logic [AXES-1:0] lim_s1_q, lim_s2_q;
	logic [31:0] arg_q, cfg_q, rdata_q;
	logic [IRQ_W-1:0] irq_q, mask_q;
	logic [AXES-1:0] sel_q, move_mask_q, armed_q, pend_q;
	logic [1:0] cur_q;
	logic prev_timed_q, kill_q;
	logic [AXES-1:0] restore_q;
	jgh_vel_t move_vel_q [AXES];
	jgh_vel_t target [AXES];
	jgh_coef_t ka_q [AXES];
	jgh_coef_t kb_q [AXES];
	logic [7:0] cost_cmd_q, cost_cmd_d;
	logic [15:0] cost_arg_q, cost_arg_d;
	logic cmd_wr;
	logic [3:0] op;
	logic [AXES-1:0] ax, stop_v, at_vel_evt, done_ack, jog_v;
	logic [31:0] arg_mag;
	jgh_vel_t jog_vel;
	logic jog_int, jog_frac, jog_ok, jog_go;
	logic set_ka, set_kb, ka_ok, kb_ok, rpt_req, rpt_go;
	logic fmt_busy, rpt_done, reject;
	logic [1:0] ax_low;
	logic [IRQ_W-1:0] irq_ev;

	// Limit pins are asynchronous
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			lim_s1_q <= '0;
			lim_s2_q <= '0;
		end else begin
			lim_s1_q <= I_LIMIT;
			lim_s2_q <= lim_s1_q;
		end
	end

	assign cmd_wr = I_WR && (I_ADDR == A_CMD); // R14
	assign op = I_WDATA[OP_LSB+:4];
	assign ax = I_WDATA[AXES-1:0];
	assign arg_mag = arg_q[31] ? (~arg_q + 32'h0000_0001) : arg_q;
	assign jog_int = cmd_wr && op == OP_JOG;
	assign jog_frac = cmd_wr && op == OP_FJOG;
	assign jog_ok = jog_int ? (arg_mag <= JOG_LIMIT) : (arg_mag <= {JOG_LIMIT[23:0], 8'h00}); // R9
	assign jog_go = (jog_int || jog_frac) && jog_ok;
	assign jog_vel = jog_int ? {arg_q[31-FRAC_BITS:0], 8'h00} : arg_q; // R3
	assign jog_v = jog_go ? sel_q : '0; // R8
	assign set_ka = cmd_wr && op == OP_SET_KA;
	assign set_kb = cmd_wr && op == OP_SET_KB;
	assign ka_ok = arg_q <= {10'h000, KA_MAX}; // R11
	assign kb_ok = arg_q <= {10'h000, KB_MAX}; // R13
	assign rpt_req = cmd_wr && (op == OP_RPT_KA || op == OP_RPT_KB);
	assign rpt_go = rpt_req && !fmt_busy; // R12
	assign reject = ((jog_int || jog_frac) && !jog_ok) || (set_ka && !ka_ok) || (set_kb && !kb_ok)
		|| (rpt_req && fmt_busy);

	// Stop sources, limits only when enabled
	always_comb begin
		stop_v = lim_s2_q & cfg_q[CFG_LIMEN_LSB+:AXES]; // R6
		if (cmd_wr && op == OP_STOP) begin
			stop_v = stop_v | sel_q;
		end
		if (cmd_wr && (op == OP_STOP_ALL || op == OP_KILL)) begin
			stop_v = '1;
		end
		if (cmd_wr && op == OP_HOLD_OFF) begin
			stop_v[cur_q] = 1'b1;
		end
	end

	always_comb begin
		ax_low = 2'h0;
		for (int i = AXES - 1; i >= 0; i--) begin
			if (ax[i]) begin
				ax_low = 2'(i);
			end
		end
	end

	// Queue cost of a jog
	always_comb begin
		cost_cmd_d = COST_JOG_CMD; // R4
		cost_arg_d = jog_int ? ARG_JG : ARG_JF;
		if (cfg_q[CFG_PA]) begin
			cost_cmd_d = 8'(cost_cmd_d + COST_ONE); // R4
		end
		if (|(sel_q & cfg_q[CFG_CLOSED_LSB+:AXES])) begin
			cost_cmd_d = 8'(cost_cmd_d + COST_ONE); // R4
		end
		if (prev_timed_q) begin
			cost_cmd_d = 8'(cost_cmd_d + COST_RESTORE_CMD); // R5
			unique case (cfg_q[CFG_RAMP_LSB+:2])
				RAMP_LIN: cost_arg_d = 16'(cost_arg_d + ARG_LIN);
				RAMP_SHORT: cost_arg_d = 16'(cost_arg_d + ARG_SHORT);
				RAMP_OTHER: cost_arg_d = 16'(cost_arg_d + ARG_OTHER);
				RAMP_CUSTOM: cost_arg_d = 16'(cost_arg_d + {7'h00, cfg_q[CFG_SEG_LSB+:8], 1'b0}
					+ ARG_CUSTOM_BASE);
			endcase
		end
	end

	// Software written registers
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			arg_q <= '0;
			cfg_q <= CFG_RST;
			mask_q <= '0;
		end else if (I_WR) begin
			if (I_ADDR == A_ARG) begin
				arg_q <= I_WDATA;
			end
			if (I_ADDR == A_CFG) begin
				cfg_q <= I_WDATA;
			end
			if (I_ADDR == A_MASK) begin
				mask_q <= I_WDATA[IRQ_W-1:0];
			end
		end
	end

	// Axis selection
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sel_q <= 4'h1;
			cur_q <= 2'h0;
		end else if (cmd_wr && op == OP_SELECT && ax != 0) begin
			sel_q <= ax; // R14
			cur_q <= ax_low;
		end
	end

	// Move history and done notification
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			move_mask_q <= '0;
			prev_timed_q <= 1'b0;
		end else if (cmd_wr && (op == OP_MOVE || op == OP_TIMED || op == OP_LINKED)) begin
			move_mask_q <= ax;
			prev_timed_q <= op != OP_MOVE; // R5
		end else if (jog_go) begin
			prev_timed_q <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			armed_q <= '0;
			pend_q <= '0;
		end else begin
			if (cmd_wr && op == OP_NOTIFY) begin
				armed_q <= move_mask_q; // R1
			end else begin
				armed_q <= armed_q & ~I_AXIS_DONE;
			end
			pend_q <= (pend_q & ~done_ack) | (I_AXIS_DONE & armed_q); // R1
		end
	end

	// Velocities and gains
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < AXES; i++) begin
				move_vel_q[i] <= '0;
				ka_q[i] <= KA_RST; // R11
				kb_q[i] <= KB_RST; // R13
			end
		end else begin
			for (int i = 0; i < AXES; i++) begin
				if (jog_v[i] || (cmd_wr && op == OP_VEL && sel_q[i])) begin
					move_vel_q[i] <= jog_v[i] ? jog_vel : arg_q; // R3
				end
			end
			if (set_ka && ka_ok) begin
				ka_q[cur_q] <= arg_q[COEF_W-1:0]; // R11
			end
			if (set_kb && kb_ok) begin
				kb_q[cur_q] <= arg_q[COEF_W-1:0]; // R13
			end
		end
	end

	// Cost record and profile restore
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cost_cmd_q <= '0;
			cost_arg_q <= '0;
			restore_q <= '0;
			kill_q <= 1'b0;
		end else begin
			restore_q <= prev_timed_q ? jog_v : '0; // R5
			kill_q <= cmd_wr && op == OP_KILL;
			if (jog_go) begin
				cost_cmd_q <= cost_cmd_d;
				cost_arg_q <= cost_arg_d;
			end
		end
	end

	// Sticky status, write one to clear, set wins
	assign irq_ev[IRQ_DONE] = |done_ack;
	assign irq_ev[IRQ_RPT] = rpt_done;
	assign irq_ev[IRQ_VEL] = |at_vel_evt;
	assign irq_ev[IRQ_REJ] = reject;
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			irq_q <= '0;
		end else begin
			irq_q <= (irq_q & ~((I_WR && I_ADDR == A_IRQ) ? I_WDATA[IRQ_W-1:0] : '0)) | irq_ev;
		end
	end
	assign O_IRQ = |(irq_q & mask_q);

	// Read data, unmapped reads zero
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_q <= '0;
		end else if (I_RD) begin
			unique case (I_ADDR)
				A_ARG: rdata_q <= arg_q;
				A_CFG: rdata_q <= cfg_q;
				A_STAT: rdata_q <= {12'h000, prev_timed_q, cur_q, fmt_busy, armed_q, O_REVERSING,
					O_JOG_RUN, sel_q};
				A_COST: rdata_q <= {8'h00, cost_arg_q, cost_cmd_q};
				A_IRQ: rdata_q <= {28'h0000000, irq_q};
				A_MASK: rdata_q <= {28'h0000000, mask_q};
				A_KA: rdata_q <= {10'h000, ka_q[cur_q]};
				A_KB: rdata_q <= {10'h000, kb_q[cur_q]};
				A_VEL: rdata_q <= move_vel_q[cur_q];
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end
	assign O_RDATA = rdata_q;
	assign O_RESTORE = restore_q;
	assign O_KILL = kill_q;

	jgh_fmt u_fmt (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_done_req(pend_q),
		.i_rpt(rpt_go),
		.i_rpt_kb(op == OP_RPT_KB),
		.i_val(op == OP_RPT_KB ? kb_q[cur_q] : ka_q[cur_q]),
		.i_tx_ready(I_TX_READY),
		.o_done_ack(done_ack),
		.o_busy(fmt_busy),
		.o_rpt_done(rpt_done),
		.o_tx_data(O_TX_DATA),
		.o_tx_valid(O_TX_VALID)
	);

	// Per axis jog sequencer and output clamp
	for (genvar g = 0; g < AXES; g++) begin : g_axis
		logic signed [15:0] lim, dac_q, pid;
		assign lim = {6'h00, kb_q[g][9:0]};
		assign pid = I_PID_OUT[16*g+:16];
		jgh_jog_axis u_jog (
			.i_clk(I_SYS_CLK),
			.i_arst_n(I_ARST_N),
			.i_jog(jog_v[g]),
			.i_vel(jog_vel),
			.i_stop(stop_v[g]),
			.i_stopped(I_STOPPED[g]),
			.i_at_vel(I_AT_VEL[g]),
			.o_target(target[g]),
			.o_run(O_JOG_RUN[g]),
			.o_reversing(O_REVERSING[g]),
			.o_at_vel_evt(at_vel_evt[g])
		);
		always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
			if (!I_ARST_N) begin
				dac_q <= '0;
			end else if (pid > lim) begin
				dac_q <= lim; // R13
			end else if (pid < -lim) begin
				dac_q <= -lim; // R13
			end else begin
				dac_q <= pid;
			end
		end
		assign O_DAC_OUT[16*g+:16] = dac_q;
		assign O_JOG_VEL[32*g+:32] = target[g];
		assign O_MOVE_VEL[32*g+:32] = move_vel_q[g];
		assign O_ACCEL_FF[COEF_W*g+:COEF_W] = ka_q[g];
		dac_clamp_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R13
			1'b1 |=> (dac_q <= $past(lim) && dac_q >= -$past(lim)))
			else $error("servo output beyond upper bound");
	end

	notify_arm_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R1
		(cmd_wr && op == OP_NOTIFY) |=> (armed_q == $past(move_mask_q)))
		else $error("notify did not arm moved axes");
	pend_set_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R1
		(|(I_AXIS_DONE & armed_q) && !(cmd_wr && op == OP_NOTIFY))
		|=> ((pend_q & $past(I_AXIS_DONE & armed_q)) == $past(I_AXIS_DONE & armed_q)
		&& (armed_q & $past(I_AXIS_DONE)) == '0))
		else $error("axis done lost");
	jog_range_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R9
		(jog_int && arg_mag > JOG_LIMIT) |=> (irq_q[IRQ_REJ] && $stable(move_vel_q[0])))
		else $error("out of range jog accepted");
	vel_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R8
		(jog_go && sel_q[0] && !stop_v[0]) |=> (move_vel_q[0] == $past(jog_vel) && O_JOG_RUN[0]))
		else $error("jog did not set velocity and start");
	ka_range_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R11
		(ka_q[0] <= KA_MAX && kb_q[0] <= KB_MAX))
		else $error("coefficient out of range");
	cost_base_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R4
		(jog_go && !cfg_q[CFG_PA] && !(|(sel_q & cfg_q[CFG_CLOSED_LSB+:AXES])) && !prev_timed_q)
		|=> (cost_cmd_q == COST_JOG_CMD))
		else $error("jog base cost wrong");
	restore_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R5
		(jog_go && prev_timed_q) |=> (O_RESTORE == $past(sel_q) && !prev_timed_q))
		else $error("profile not restored before jog");
endmodule // jgh_top

/* test/jgh_host_sink.sv */
// Host side byte receiver that stalls every other cycle
`timescale 1ns/10ps
module jgh_host_sink (
	input wire logic i_clk, // System clock
	input wire logic i_valid, // Byte valid
	input wire logic [7:0] i_data, // Byte from device
	output logic o_ready // Host accepts byte
);
	logic [7:0] rxq [$];
	initial begin
		o_ready = 1'b0;
	end
	always @(posedge i_clk) begin
		if (i_valid && o_ready) begin
			rxq.push_back(i_data);
		end
		o_ready <= ~o_ready;
	end
endmodule // jgh_host_sink

/* test/jgh_top_bench.sv */
// Bench for the jog and gain command handler
`timescale 1ns/10ps
module jgh_top_bench;
	import jgh_pkg::*;
	logic clk, arst_n, wr, rd, irq, tx_valid, tx_ready, kill;
	logic [5:0] addr;
	logic [31:0] wdata, rdata;
	logic [7:0] tx_data;
	logic [3:0] done, at_vel, stopped, limit, run, rev, restore;
	logic [63:0] pid, dac;
	logic [127:0] jvel, mvel;
	logic [87:0] aff;
	int err_total, total_checks;
	logic [7:0] exp_rpt [8] = '{CH_K, CH_A, 8'h31, CH_0, CH_DOT, 8'h35, CH_0, CH_LF};
	jgh_top DUT (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_AXIS_DONE(done), .I_AT_VEL(at_vel),
		.I_STOPPED(stopped), .I_LIMIT(limit), .I_PID_OUT(pid), .I_TX_READY(tx_ready),
		.O_TX_DATA(tx_data), .O_TX_VALID(tx_valid), .O_JOG_VEL(jvel), .O_JOG_RUN(run), .O_REVERSING(rev),
		.O_MOVE_VEL(mvel), .O_RESTORE(restore), .O_KILL(kill), .O_ACCEL_FF(aff), .O_DAC_OUT(dac));
	jgh_host_sink HOST (.i_clk(clk), .i_valid(tx_valid), .i_data(tx_data), .o_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic wait_bytes(input int n);
		int i;
		for (i = 0; i < 400 && HOST.rxq.size() < n; i++) begin
			@(posedge clk);
		end
		chk(32'(HOST.rxq.size()), 32'(n));
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
	initial begin
		err_total = 0;
		total_checks = 0;
		arst_n = 1'b0;
		{wr, rd, addr, wdata, done, at_vel, stopped, limit, pid} = '0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(A_KA, 32'h0);
		rd_chk(A_KB, 32'h0);
		wr_reg(A_ARG, 32'd1050);
		wr_reg(A_CMD, {OP_SET_KA, 28'h0});
		rd_chk(A_KA, 32'd1050);
		chk({10'h000, aff[21:0]}, 32'h0000_041A);
		@(posedge clk) pid <= 64'h0000_0000_0000_01F4;
		repeat (2) @(posedge clk);
		#1;
		chk({16'h0000, dac[15:0]}, 32'h0);
		wr_reg(A_ARG, 32'h0000_012C);
		wr_reg(A_CMD, {OP_SET_KB, 28'h0});
		repeat (2) @(posedge clk);
		#1;
		chk({16'h0000, dac[15:0]}, 32'h0000_012C);
		wr_reg(A_CMD, {OP_RPT_KA, 28'h0});
		wait_bytes(8);
		for (int i = 0; i < 8; i++) begin
			chk({24'h0, HOST.rxq[i]}, {24'h0, exp_rpt[i]});
		end
		HOST.rxq.delete();
		wr_reg(A_MASK, 32'h1);
		wr_reg(A_CMD, {OP_MOVE, 24'h0, 4'hA});
		wr_reg(A_CMD, {OP_NOTIFY, 28'h0});
		@(posedge clk) done <= 4'b0010;
		@(posedge clk) done <= 4'b1000;
		@(posedge clk) done <= 4'b0000;
		wait_bytes(2);
		chk({24'h0, HOST.rxq[0]}, 32'h81);
		chk({24'h0, HOST.rxq[1]}, 32'h83);
		repeat (3) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr_reg(A_IRQ, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr_reg(A_CFG, 32'h11);
		wr_reg(A_ARG, 32'd100);
		wr_reg(A_CMD, {OP_JOG, 24'h0, 4'h1});
		#1;
		chk({28'h0, run}, 32'h1);
		chk(jvel[31:0], 32'h0000_6400);
		chk(mvel[31:0], 32'h0000_6400);
		rd_chk(A_COST, {8'h0, 16'h0001, 8'h05});
		rd_chk(A_VEL, 32'h6400);
		wr_reg(A_ARG, 32'hFFFF_FF9C);
		wr_reg(A_CMD, {OP_JOG, 24'h0, 4'h1});
		#1;
		chk({28'h0, rev}, 32'h1);
		chk(jvel[31:0], 32'h0);
		@(posedge clk) stopped <= 4'h1;
		@(posedge clk) stopped <= 4'h0;
		#1;
		chk(jvel[31:0], 32'hFFFF_9C00);
		@(posedge clk) at_vel <= 4'h1;
		@(posedge clk) at_vel <= 4'h0;
		wr_reg(A_CMD, {OP_KILL, 28'h0});
		#1;
		chk({27'h0, kill, run}, 32'h10);
		wr_reg(A_CMD, {OP_TIMED, 24'h0, 4'h1});
		wr_reg(A_CMD, {OP_JOG, 24'h0, 4'h1});
		#1;
		chk({28'h0, restore}, 32'h1);
		rd_chk(A_COST, {8'h0, 16'h0005, 8'h09});
		wr_reg(A_ARG, 32'h000F_EE21);
		wr_reg(A_CMD, {OP_JOG, 24'h0, 4'h1});
		rd_chk(A_IRQ, 32'hE);
		rd_chk(A_VEL, 32'hFFFF_9C00);
		print_verdict();
	end
endmodule // jgh_top_bench
